// File: table_read_xor_execute_tb_top.sv
`timescale 1ns/100ps
module table_read_xor_execute_tb_top;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] pm_wait = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, pm_ack;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] pm_rdata;
    logic [7:0] df_rdata;
    trxe_pkg::trxe_pm_req_s pm_req;
    trxe_pkg::trxe_df_req_s df_req;
    int err_count = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic [20:0] p, q, e;
    logic [15:0] wd;

    always #4 sys_clk = ~sys_clk;

    trxe_core DUT (.sys_clk(sys_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pm_req(pm_req),
        .pm_ack(pm_ack), .pm_rdata(pm_rdata), .df_req(df_req), .df_rdata(df_rdata));

    trxe_mem_model mem_i (.sys_clk(sys_clk), .reset_n(reset_n), .pm_wait(pm_wait), .pm_req(pm_req),
        .df_req(df_req), .pm_ack(pm_ack), .pm_rdata(pm_rdata), .df_rdata(df_rdata));

    task automatic close_out();
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad;
        logic dd;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge sys_clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            ad = ad | awready;
            dd = dd | wready;
        end
        bready <= 1'b1;
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        d = rdata;
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
    endtask

    // Starts an instruction and polls until the busy flag clears
    task automatic go(input logic [15:0] op);
        logic [31:0] s;
        axw(trxe_pkg::OFF_INSTR, {16'h0000, op}, trxe_pkg::RESP_OKAY);
        for (int i = 0; i < 40; i++)
        begin
            axr(trxe_pkg::OFF_STATUS, s, trxe_pkg::RESP_OKAY);
            if (s[trxe_pkg::ST_BUSY_BIT] === 1'b0)
                break;
        end
    endtask

    task automatic xc(input logic d, input logic a, input logic x, input logic [3:0] bk, input logic [11:0] ix,
        input logic [7:0] f, input logic [7:0] w, input logic [7:0] fv);
        logic [11:0] ea;
        logic [7:0] r;
        logic [31:0] v;
        ea = a ? {bk, f} : (f > 8'h5F) ? {4'hF, f} : x ? ix + {4'h0, f} : {4'h0, f};
        r = w ^ fv;
        mem_i.mem[ea] = fv;
        axw(trxe_pkg::OFF_CTRL, {31'h0, x}, trxe_pkg::RESP_OKAY);
        axw(trxe_pkg::OFF_BANK, {28'h0, bk}, trxe_pkg::RESP_OKAY);
        axw(trxe_pkg::OFF_INDEX, {20'h0, ix}, trxe_pkg::RESP_OKAY);
        axw(trxe_pkg::OFF_WREG, {24'h0, w}, trxe_pkg::RESP_OKAY);
        go({6'h06, d, a, f});
        axr(trxe_pkg::OFF_WREG, v, trxe_pkg::RESP_OKAY);
        chk("wreg", {24'h0, d ? w : r}, v);
        chk("file", {24'h0, d ? r : fv}, {24'h0, mem_i.mem[ea]});
        axr(trxe_pkg::OFF_STATUS, v, trxe_pkg::RESP_OKAY);
        chk("neg", {31'h0, r[7]}, {31'h0, v[trxe_pkg::ST_NEG_BIT]});
        chk("zero", {31'h0, r == 8'h00}, {31'h0, v[trxe_pkg::ST_ZERO_BIT]});
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        close_out();
    end

    initial
    begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        axr(trxe_pkg::OFF_PTR, rd, trxe_pkg::RESP_OKAY);
        chk("ptr_reset", 32'h00000000, rd);
        for (int m = 0; m < 4; m++)
        begin
            p = (m == 0) ? 21'h00A356 : (m == 1) ? 21'h1FFFFF : (m == 2) ? 21'h000000 : 21'h01A357;
            pm_wait <= m[3:0] * 4'h2;
            axw(trxe_pkg::OFF_PTR, {11'h0, p}, trxe_pkg::RESP_OKAY);
            go(16'h0008 | m[15:0]);
            q = (m == 3) ? p + 21'h000001 : p;
            e = (m == 0) ? p : (m == 2) ? p - 21'h000001 : p + 21'h000001;
            wd = {~q[8:1], q[8:1] ^ q[16:9]};
            axr(trxe_pkg::OFF_LATCH, rd, trxe_pkg::RESP_OKAY);
            chk("latch", {24'h0, q[0] ? wd[15:8] : wd[7:0]}, rd);
            axr(trxe_pkg::OFF_PTR, rd, trxe_pkg::RESP_OKAY);
            chk("ptr", {11'h0, e}, rd);
        end
        axw(trxe_pkg::OFF_LATCH, 32'h000000FF, trxe_pkg::RESP_OKAY);
        axr(trxe_pkg::OFF_LATCH, rd, trxe_pkg::RESP_OKAY);
        chk("latch_ro", {24'h0, wd[7:0]}, rd);
        axw(8'h40, 32'h00000001, trxe_pkg::RESP_SLVERR);
        axr(8'h40, rd, trxe_pkg::RESP_SLVERR);
        xc(1'b1, 1'b0, 1'b0, 4'h0, 12'h000, 8'h5F, 8'hB5, 8'hAF);
        xc(1'b0, 1'b0, 1'b0, 4'h0, 12'h000, 8'h60, 8'h5A, 8'h5A);
        xc(1'b0, 1'b1, 1'b1, 4'h3, 12'h100, 8'h10, 8'h80, 8'h01);
        xc(1'b1, 1'b0, 1'b1, 4'h3, 12'hFF0, 8'h20, 8'h0F, 8'hF0);
        xc(1'b0, 1'b0, 1'b1, 4'h2, 12'h200, 8'h60, 8'h11, 8'h22);
        // Slow program memory keeps the first read busy, so the second start is dropped
        pm_wait <= 4'hF;
        axw(trxe_pkg::OFF_INSTR, 32'h00000008, trxe_pkg::RESP_OKAY);
        go(16'h0008);
        axr(trxe_pkg::OFF_STATUS, rd, trxe_pkg::RESP_OKAY);
        chk("dropped_set", 32'h00000010, rd & 32'h00000018);
        axw(trxe_pkg::OFF_STATUS, 32'h00000010, trxe_pkg::RESP_OKAY);
        go(16'hFFFF);
        axr(trxe_pkg::OFF_STATUS, rd, trxe_pkg::RESP_OKAY);
        chk("bad_set", 32'h00000008, rd & 32'h00000018);
        axr(trxe_pkg::OFF_INSTR, rd, trxe_pkg::RESP_OKAY);
        chk("instr", 32'h0000FFFF, rd);
        axw(trxe_pkg::OFF_STATUS, 32'h00000008, trxe_pkg::RESP_OKAY);
        axr(trxe_pkg::OFF_STATUS, rd, trxe_pkg::RESP_OKAY);
        chk("flags_clear", 32'h00000000, rd & 32'h00000018);
        close_out();
    end
endmodule

// File: trxe_core.sv
`timescale 1ns/100ps
module trxe_core (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output trxe_pkg::trxe_pm_req_s pm_req,
    input wire logic pm_ack,
    input wire logic [15:0] pm_rdata,
    output trxe_pkg::trxe_df_req_s df_req,
    input wire logic [7:0] df_rdata
);
    trxe_pkg::trxe_state_e state;
    trxe_pkg::trxe_state_e next_state;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [15:0] instr;
    logic [7:0] wreg;
    logic [7:0] next_wreg;
    logic [20:0] ptr;
    logic [20:0] next_ptr;
    logic [7:0] latch;
    logic [3:0] bank;
    logic ext_en;
    logic [11:0] index_base;
    logic neg;
    logic zero;
    logic bad_op;
    logic dropped;
    logic [11:0] eff_addr;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] mask;
        mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~mask) | (val & mask);
    endfunction

    // Bus decode
    wire wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire rd_fire = s_axi_arvalid & s_axi_arready;
    wire sel_instr = wr_fire && (aw_addr == trxe_pkg::OFF_INSTR);
    wire sel_status = wr_fire && (aw_addr == trxe_pkg::OFF_STATUS);
    wire sel_wreg = wr_fire && (aw_addr == trxe_pkg::OFF_WREG);
    wire sel_ptr = wr_fire && (aw_addr == trxe_pkg::OFF_PTR);
    wire sel_latch = wr_fire && (aw_addr == trxe_pkg::OFF_LATCH);
    wire sel_bank = wr_fire && (aw_addr == trxe_pkg::OFF_BANK);
    wire sel_ctrl = wr_fire && (aw_addr == trxe_pkg::OFF_CTRL);
    wire sel_index = wr_fire && (aw_addr == trxe_pkg::OFF_INDEX);
    wire wr_mapped = sel_instr | sel_status | sel_wreg | sel_ptr | sel_latch | sel_bank | sel_ctrl | sel_index;

    wire [31:0] instr_wr = merge({16'h0000, instr}, w_data, w_strb);
    wire [31:0] wreg_wr = merge({24'h000000, wreg}, w_data, w_strb);
    wire [31:0] ptr_wr = merge({11'h000, ptr}, w_data, w_strb);
    wire [31:0] bank_wr = merge({28'h0000000, bank}, w_data, w_strb);
    wire [31:0] ctrl_wr = merge({31'h00000000, ext_en}, w_data, w_strb);
    wire [31:0] index_wr = merge({20'h00000, index_base}, w_data, w_strb);
    wire clr_bad = sel_status && w_strb[0] && w_data[trxe_pkg::ST_BADOP_BIT];
    wire clr_drop = sel_status && w_strb[0] && w_data[trxe_pkg::ST_DROP_BIT];

    // Instruction decode
    wire busy = state != trxe_pkg::ST_IDLE;
    wire [15:0] new_op = instr_wr[15:0];
    wire is_tb = new_op[15:2] == trxe_pkg::TB_OPCODE;
    wire is_xor = new_op[15:10] == trxe_pkg::XOR_OPCODE;
    wire start_ok = sel_instr && !busy;
    wire tb_start = start_ok && is_tb;
    wire xr_start = start_ok && is_xor;
    wire bad_start = start_ok && !is_tb && !is_xor;
    wire drop_start = sel_instr && busy;
    wire [1:0] new_mode = new_op[1:0];
    wire [1:0] cur_mode = instr[1:0];
    wire dest_file = instr[trxe_pkg::OP_DEST_BIT];
    wire tb_done = (state == trxe_pkg::ST_READ) && pm_ack;
    wire [7:0] byte_sel = ptr[0] ? pm_rdata[15:8] : pm_rdata[7:0];
    wire [7:0] xor_res = wreg ^ df_rdata;
    wire res_neg = xor_res[7];
    wire res_zero = xor_res == 8'h00;

    trxe_file_addr u_file_addr (
        .file_sel(new_op[7:0]),
        .banked(new_op[trxe_pkg::OP_BANKED_BIT]),
        .ext_en(ext_en),
        .bank(bank),
        .index_base(index_base),
        .file_addr(eff_addr)
    );

    always_comb
    begin
        next_state = state;
        case (state)
            trxe_pkg::ST_IDLE:
            begin
                if (tb_start)
                    next_state = (new_mode == trxe_pkg::MODE_PRE_INC) ? trxe_pkg::ST_PRE : trxe_pkg::ST_READ;
                else if (xr_start)
                    next_state = trxe_pkg::ST_XRD;
            end
            trxe_pkg::ST_PRE: next_state = trxe_pkg::ST_READ;
            trxe_pkg::ST_READ: if (pm_ack) next_state = trxe_pkg::ST_IDLE;
            trxe_pkg::ST_XRD: next_state = trxe_pkg::ST_IDLE;
            default: next_state = trxe_pkg::ST_IDLE;
        endcase
    end

    // Pointer update; the byte is taken at the same edge from the old value
    always_comb
    begin
        next_ptr = ptr;
        case (state)
            trxe_pkg::ST_IDLE: if (sel_ptr) next_ptr = ptr_wr[20:0];
            trxe_pkg::ST_PRE: next_ptr = ptr + trxe_pkg::PTR_STEP;
            trxe_pkg::ST_READ:
            begin
                if (pm_ack && cur_mode == trxe_pkg::MODE_POST_INC)
                    next_ptr = ptr + trxe_pkg::PTR_STEP;
                else if (pm_ack && cur_mode == trxe_pkg::MODE_POST_DEC)
                    next_ptr = ptr - trxe_pkg::PTR_STEP;
            end
            default: next_ptr = ptr;
        endcase
    end

    always_comb
    begin
        next_wreg = wreg;
        if (state == trxe_pkg::ST_XRD && !dest_file)
            next_wreg = xor_res;
        else if (sel_wreg && !busy)
            next_wreg = wreg_wr[7:0];
    end

    // Read data selection
    wire [7:0] ra = s_axi_araddr;
    wire rd_mapped = (ra == trxe_pkg::OFF_INSTR) || (ra == trxe_pkg::OFF_STATUS) || (ra == trxe_pkg::OFF_WREG) ||
                     (ra == trxe_pkg::OFF_PTR) || (ra == trxe_pkg::OFF_LATCH) || (ra == trxe_pkg::OFF_BANK) ||
                     (ra == trxe_pkg::OFF_CTRL) || (ra == trxe_pkg::OFF_INDEX);
    wire [31:0] status_word = {27'h0000000, dropped, bad_op, zero, neg, busy};
    wire [31:0] rd_word = (ra == trxe_pkg::OFF_INSTR) ? {16'h0000, instr} :
                          (ra == trxe_pkg::OFF_STATUS) ? status_word :
                          (ra == trxe_pkg::OFF_WREG) ? {24'h000000, wreg} :
                          (ra == trxe_pkg::OFF_PTR) ? {11'h000, ptr} :
                          (ra == trxe_pkg::OFF_LATCH) ? {24'h000000, latch} :
                          (ra == trxe_pkg::OFF_BANK) ? {28'h0000000, bank} :
                          (ra == trxe_pkg::OFF_CTRL) ? {31'h00000000, ext_en} :
                          (ra == trxe_pkg::OFF_INDEX) ? {20'h00000, index_base} : 32'h00000000;

    // Write channels
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= trxe_pkg::RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? trxe_pkg::RESP_OKAY : trxe_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= trxe_pkg::RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_mapped ? trxe_pkg::RESP_OKAY : trxe_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // Configuration and sticky flags; a new event beats a clear
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            bank <= 4'h0;
            ext_en <= 1'b0;
            index_base <= 12'h000;
            bad_op <= 1'b0;
            dropped <= 1'b0;
            instr <= 16'h0000;
        end
        else
        begin
            if (sel_bank) bank <= bank_wr[3:0];
            if (sel_ctrl) ext_en <= ctrl_wr[trxe_pkg::CTRL_EXT_BIT];
            if (sel_index) index_base <= index_wr[11:0];
            if (start_ok) instr <= new_op;
            bad_op <= bad_start | (bad_op & ~clr_bad);
            dropped <= drop_start | (dropped & ~clr_drop);
        end
    end

    // Sequencer and data path
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state <= trxe_pkg::ST_IDLE;
            ptr <= trxe_pkg::PTR_RESET;
            wreg <= trxe_pkg::BYTE_RESET;
            latch <= trxe_pkg::BYTE_RESET;
            neg <= 1'b0;
            zero <= 1'b0;
            pm_req <= '0;
            df_req <= '0;
        end
        else
        begin
            state <= next_state;
            ptr <= next_ptr;
            wreg <= next_wreg;
            pm_req.req <= next_state == trxe_pkg::ST_READ;
            pm_req.word_addr <= next_ptr[20:1];
            if (tb_done) latch <= byte_sel;
            df_req.rd <= next_state == trxe_pkg::ST_XRD;
            df_req.we <= (state == trxe_pkg::ST_XRD) && dest_file;
            if (xr_start) df_req.addr <= eff_addr;
            if (state == trxe_pkg::ST_XRD)
            begin
                df_req.wdata <= xor_res;
                neg <= res_neg;
                zero <= res_zero;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_pre_mode_decode: assert property (tb_start && new_mode == 2'h3
        |=> state == trxe_pkg::ST_PRE ##1 pm_req.req)
        else $error("pre-increment not decoded");
    a_read_mode_decode: assert property (tb_start && new_mode != 2'h3
        |=> state == trxe_pkg::ST_READ && pm_req.req)
        else $error("read mode not decoded");
    a_keep_ptr_hold: assert property (tb_done && cur_mode == 2'h0 |=> ptr == $past(ptr))
        else $error("pointer moved in keep mode");
    a_post_inc_step: assert property (tb_done && cur_mode == 2'h1 |=> ptr == $past(ptr) + 21'h000001)
        else $error("post-increment wrong");
    a_post_dec_step: assert property (tb_done && cur_mode == 2'h2 |=> ptr == $past(ptr) - 21'h000001)
        else $error("post-decrement wrong");
    a_pre_inc_addr: assert property (state == trxe_pkg::ST_PRE
        |=> ptr == $past(ptr) + 21'h000001 && pm_req.word_addr == ptr[20:1])
        else $error("pre-increment wrong");
    a_word_addr_track: assert property (pm_req.req |-> pm_req.word_addr == ptr[20:1])
        else $error("program word address off pointer");
    a_byte_half_sel: assert property (tb_done |=> latch == $past(byte_sel) && $stable(wreg))
        else $error("wrong byte latched");
    a_xor_flags: assert property (state == trxe_pkg::ST_XRD
        |=> neg == $past(res_neg) && zero == $past(res_zero))
        else $error("xor flags wrong");
    a_flags_hold: assert property (state != trxe_pkg::ST_XRD |=> $stable(neg) && $stable(zero))
        else $error("flags changed outside xor");
    a_dest_file: assert property (state == trxe_pkg::ST_XRD && dest_file
        |=> df_req.we && df_req.wdata == $past(xor_res) && $stable(wreg))
        else $error("xor file write wrong");
    a_dest_accum: assert property (state == trxe_pkg::ST_XRD && !dest_file
        |=> !df_req.we && wreg == $past(xor_res))
        else $error("xor accumulator write wrong");
    a_bank_access: assert property (xr_start && new_op[8]
        |=> df_req.addr == {$past(bank), $past(new_op[7:0])} && df_req.rd)
        else $error("banked address wrong");
    a_indexed_offset: assert property (xr_start && !new_op[8] && ext_en && new_op[7:0] <= 8'h5F
        |=> df_req.addr == 12'($past(index_base) + {4'h0, $past(new_op[7:0])}))
        else $error("indexed address wrong");

    c_pre_inc_read: cover property (tb_start && new_mode == 2'h3 ##[1:40] tb_done);
    c_post_dec_read: cover property (tb_start && new_mode == 2'h2 ##[1:40] tb_done);
    c_xor_to_file: cover property (xr_start ##1 state == trxe_pkg::ST_XRD && dest_file);
    c_xor_to_accum: cover property (xr_start ##1 state == trxe_pkg::ST_XRD && !dest_file);
endmodule

// File: trxe_file_addr.sv
`timescale 1ns/100ps
module trxe_file_addr (
    input wire logic [7:0] file_sel,
    input wire logic banked,
    input wire logic ext_en,
    input wire logic [3:0] bank,
    input wire logic [11:0] index_base,
    output logic [11:0] file_addr
);
    wire low_page = file_sel <= trxe_pkg::ACCESS_LOW_LAST;
    wire [11:0] indexed = index_base + {4'h0, file_sel};
    wire [11:0] access = low_page ? {4'h0, file_sel} : {trxe_pkg::ACCESS_HIGH_PAGE, file_sel};

    assign file_addr = banked ? {bank, file_sel} :
                       (ext_en && low_page) ? indexed : access;
endmodule

// File: trxe_mem_model.sv
`timescale 1ns/100ps
module trxe_mem_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] pm_wait,
    input wire trxe_pkg::trxe_pm_req_s pm_req,
    input wire trxe_pkg::trxe_df_req_s df_req,
    output logic pm_ack,
    output logic [15:0] pm_rdata,
    output logic [7:0] df_rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_rd;
    logic [3:0] wait_cnt;

    initial
    begin
        for (int i = 0; i < 4096; i++)
            mem[i] = 8'h3C ^ i[7:0];
        last_rd = 8'h00;
    end

    // Program word content follows its word address; between acks the data bus toggles
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            pm_ack <= 1'b0;
            wait_cnt <= 4'h0;
            pm_rdata <= 16'h0000;
        end
        else if (pm_req.req && !pm_ack && wait_cnt == pm_wait)
        begin
            pm_ack <= 1'b1;
            pm_rdata <= {~pm_req.word_addr[7:0], pm_req.word_addr[7:0] ^ pm_req.word_addr[15:8]};
            wait_cnt <= 4'h0;
        end
        else
        begin
            pm_ack <= 1'b0;
            pm_rdata <= ~pm_rdata;
            wait_cnt <= (pm_req.req && !pm_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
    end

    // Asynchronous-read file; outside a read the data lines show the inverse of the last value
    always @(posedge sys_clk)
    begin
        if (df_req.we)
            mem[df_req.addr] <= df_req.wdata;
        if (df_req.rd)
            last_rd <= mem[df_req.addr];
    end
    assign df_rdata = df_req.rd ? mem[df_req.addr] : ~last_rd;
endmodule

// File: trxe_pkg.sv
package trxe_pkg;

    localparam int unsigned PTR_W = 21;
    localparam int unsigned PM_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned FILE_AW = 12;
    localparam int unsigned REG_AW = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_WREG = 8'h08;
    localparam logic [7:0] OFF_PTR = 8'h0C;
    localparam logic [7:0] OFF_LATCH = 8'h10;
    localparam logic [7:0] OFF_BANK = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_INDEX = 8'h1C;

    // Status and control bit positions
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_NEG_BIT = 1;
    localparam int unsigned ST_ZERO_BIT = 2;
    localparam int unsigned ST_BADOP_BIT = 3;
    localparam int unsigned ST_DROP_BIT = 4;
    localparam int unsigned CTRL_EXT_BIT = 0;

    // Opcode fields
    localparam logic [13:0] TB_OPCODE = 14'h0002;
    localparam logic [5:0] XOR_OPCODE = 6'h06;
    localparam int unsigned OP_DEST_BIT = 9;
    localparam int unsigned OP_BANKED_BIT = 8;

    // Access bank split: addresses up to this value sit in the low page
    localparam logic [7:0] ACCESS_LOW_LAST = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;

    // Reset values and pointer step
    localparam logic [20:0] PTR_RESET = 21'h000000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [20:0] PTR_STEP = 21'h000001;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        MODE_KEEP = 2'h0,
        MODE_POST_INC = 2'h1,
        MODE_POST_DEC = 2'h2,
        MODE_PRE_INC = 2'h3
    } trxe_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PRE = 3'h1,
        ST_READ = 3'h3,
        ST_XRD = 3'h2
    } trxe_state_e;

    typedef struct packed {
        logic req;
        logic [PTR_W-2:0] word_addr;
    } trxe_pm_req_s;

    typedef struct packed {
        logic rd;
        logic we;
        logic [FILE_AW-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } trxe_df_req_s;

endpackage
